// file: src/sws_defs.svh
// Register indices, reset values and wait counts of the stop/wake and reset sequencer
`ifndef SWS_DEFS_SVH
`define SWS_DEFS_SVH

// Register file size and index width
`define SWS_NUM_REGS          20
`define SWS_IDX_W             5
`define SWS_APB_AW            8

// Register indices, byte address is four times the index
`define SWS_IDX_STAB_SEL      5'h00
`define SWS_IDX_PSW           5'h01
`define SWS_IDX_PCC           5'h02
`define SWS_IDX_PORT0_LATCH   5'h03
`define SWS_IDX_PORT2_LATCH   5'h04
`define SWS_IDX_PORT0_DIR     5'h05
`define SWS_IDX_PORT2_DIR     5'h06
`define SWS_IDX_IRQ_REQ       5'h07
`define SWS_IDX_IRQ_MASK      5'h08
`define SWS_IDX_EEPROM_WC     5'h09
`define SWS_IDX_TIMER_A_CNT   5'h0A
`define SWS_IDX_TIMER_B_CNT   5'h0B
`define SWS_IDX_TIMER_A_MODE  5'h0C
`define SWS_IDX_TIMER_B_MODE  5'h0D
`define SWS_IDX_CARRIER_CTL   5'h0E
`define SWS_IDX_WDT_CLK_SEL   5'h0F
`define SWS_IDX_WDT_MODE      5'h10
`define SWS_IDX_LV_FLAGS      5'h11
`define SWS_IDX_LV_LEVEL      5'h12
`define SWS_IDX_POC_FLAGS     5'h13
`define SWS_IDX_STATUS        5'h14

// Reset values
`define SWS_RST_STAB_SEL      8'h04
`define SWS_RST_PSW           8'h02
`define SWS_RST_PCC           8'h02
`define SWS_RST_LATCH         8'h00
`define SWS_RST_DIR           8'hFF
`define SWS_RST_IRQ_REQ       8'h00
`define SWS_RST_IRQ_MASK      8'hFF
`define SWS_RST_EEPROM_WC     8'h08
`define SWS_RST_CLEARED       8'h00
`define SWS_RST_POC_NORMAL    8'h00
`define SWS_RST_POC_AFTER_POC 8'h04
`define SWS_RESET_VECTOR_ADDR 16'h0000

// Field positions
`define SWS_PSW_IE_BIT        7

// Stabilization select codes
`define SWS_STAB_CODE_SHORT   3'b000
`define SWS_STAB_CODE_MID     3'b010
`define SWS_STAB_CODE_LONG    3'b100

// Stabilization waits in oscillator cycles
`define SWS_CNT_W             18
`define SWS_STAB_SHORT_CYC    4096
`define SWS_STAB_MID_CYC      32768
`define SWS_STAB_LONG_CYC     131072
`define SWS_STAB_RC_CYC       128
`define SWS_STAB_RESET_CYC    32768

`endif

// file: src/sws_pkg.sv
// Types of the stop/wake and reset sequencer
`include "sws_defs.svh"

package sws_pkg;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_RUN,
      ST_STOP,
      ST_WAKE_WAIT,
      ST_SYS_RESET,
      ST_RESET_WAIT
   } sws_state_type;

   // Kind of vectored entry handed to the core
   typedef enum logic [1:0] {
      VEC_NONE,
      VEC_RESET,
      VEC_MASKABLE,
      VEC_KEY_NMI
   } sws_vec_type;

   typedef logic [`SWS_NUM_REGS-1:0][7:0] sws_regs_type;

   // Whole state of the sequencer
   typedef struct packed {
      sws_state_type       state;
      logic [`SWS_CNT_W-1:0] cnt;
      sws_regs_type        regs;
      logic                rst_s1;
      logic                rst_s2;
      logic                poc_s1;
      logic                poc_s2;
      logic                key_s1;
      logic                key_s2;
      logic                from_stop;
      logic                poc_cause;
      logic                nmi_wake;
      logic                ram_retain;
      logic [31:0]         prdata;
      logic                pready;
      logic                pslverr;
      logic                pins_hiz;
      logic                core_run;
      logic                pc_valid;
      logic                vector_req;
      sws_vec_type         vector_kind;
      logic [15:0]         vector_addr;
      logic                resume_next;
      logic                stop_active;
      logic                osc_enable;
      logic [7:0]          port0_out;
      logic [7:0]          port0_oe_n;
      logic [7:0]          port2_out;
      logic [7:0]          port2_oe_n;
   } sws_seq_type;

endpackage

// file: src/sws_sequencer.sv
// Stop-mode wake and system reset sequencer with APB register file
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/100ps
`include "sws_defs.svh"

module sws_sequencer #(
   parameter int RC_VARIANT     = 0,
   parameter int EEPROM_VARIANT = 0,
   parameter int STAB_MID_CYC   = `SWS_STAB_MID_CYC,
   parameter int STAB_LONG_CYC  = `SWS_STAB_LONG_CYC,
   parameter int STAB_RESET_CYC = `SWS_STAB_RESET_CYC
) (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic [`SWS_APB_AW-1:0] paddr,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [31:0]            pwdata,
   input  wire logic [3:0]             pstrb,
   output logic [31:0]                 prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic                   reset_pin_n,
   input  wire logic                   poc_detect,
   input  wire logic                   key_return_n,
   input  wire logic                   wdt_overflow,
   input  wire logic                   stop_request,
   input  wire logic [7:0]             irq_lines,
   output logic                        pins_hiz,
   output logic                        core_run,
   output logic                        pc_valid,
   output logic                        vector_req,
   output sws_pkg::sws_vec_type        vector_kind,
   output logic [15:0]                 vector_addr,
   output logic                        resume_next,
   output logic                        stop_active,
   output logic                        osc_enable,
   output logic                        ram_retain,
   output logic [7:0]                  port0_out,
   output logic [7:0]                  port0_oe_n,
   output logic [7:0]                  port2_out,
   output logic [7:0]                  port2_oe_n
);
   import sws_pkg::*;

   // Post-reset value of one register
   function automatic logic [7:0] reg_reset(input logic [`SWS_IDX_W-1:0] idx,
                                            input logic                  power_on_clear_detector);
      logic [7:0] v;
      v = `SWS_RST_CLEARED;
      unique case (idx)
         `SWS_IDX_STAB_SEL:    v = (RC_VARIANT != 0) ? `SWS_RST_CLEARED
                                                     : `SWS_RST_STAB_SEL;
         `SWS_IDX_PSW:         v = `SWS_RST_PSW;
         `SWS_IDX_PCC:         v = `SWS_RST_PCC;
         `SWS_IDX_PORT0_LATCH: v = `SWS_RST_LATCH;
         `SWS_IDX_PORT2_LATCH: v = `SWS_RST_LATCH;
         `SWS_IDX_PORT0_DIR:   v = `SWS_RST_DIR;
         `SWS_IDX_PORT2_DIR:   v = `SWS_RST_DIR;
         `SWS_IDX_IRQ_REQ:     v = `SWS_RST_IRQ_REQ;
         `SWS_IDX_IRQ_MASK:    v = `SWS_RST_IRQ_MASK;
         `SWS_IDX_EEPROM_WC:   v = (EEPROM_VARIANT != 0) ? `SWS_RST_EEPROM_WC
                                                         : `SWS_RST_CLEARED;
         `SWS_IDX_POC_FLAGS:   v = power_on_clear_detector ? `SWS_RST_POC_AFTER_POC
                                       : `SWS_RST_POC_NORMAL;
         default:              v = `SWS_RST_CLEARED;
      endcase
      return v;
   endfunction

   // Whole register file at its post-reset values
   function automatic sws_regs_type regs_reset(input logic power_on_clear_detector);
      sws_regs_type rv;
      rv = '0;
      for (int i = 0; i < `SWS_NUM_REGS; i++) begin
         rv[i] = reg_reset(`SWS_IDX_W'(i), power_on_clear_detector);
      end
      return rv;
   endfunction

   // Register index decode of an APB address
   function automatic logic [`SWS_IDX_W-1:0] addr_index(input logic [`SWS_APB_AW-1:0] a);
      return a[`SWS_IDX_W+1:2];
   endfunction

   // Whether an index is a register present on this variant
   function automatic logic reg_present(input logic [`SWS_IDX_W-1:0] idx);
      logic ok;
      ok = (idx <= `SWS_IDX_STATUS);
      if (idx == `SWS_IDX_STAB_SEL && RC_VARIANT != 0) begin
         ok = 1'b0;
      end
      if (idx == `SWS_IDX_EEPROM_WC && EEPROM_VARIANT == 0) begin
         ok = 1'b0;
      end
      return ok;
   endfunction

   // Wake wait after an interrupt release, as a load value
   function automatic logic [`SWS_CNT_W-1:0] wake_load(input logic [2:0] code);
      int cyc;
      if (RC_VARIANT != 0) begin
         cyc = `SWS_STAB_RC_CYC;
      end else begin
         unique case (code)
            `SWS_STAB_CODE_SHORT: cyc = `SWS_STAB_SHORT_CYC;
            `SWS_STAB_CODE_MID:   cyc = STAB_MID_CYC;
            default:              cyc = STAB_LONG_CYC;
         endcase
      end
      return `SWS_CNT_W'(cyc - 1);
   endfunction

   // Reset release wait as a load value
   function automatic logic [`SWS_CNT_W-1:0] reset_load();
      int cyc;
      cyc = (RC_VARIANT != 0) ? `SWS_STAB_RC_CYC : STAB_RESET_CYC;
      return `SWS_CNT_W'(cyc - 1);
   endfunction

   localparam sws_regs_type REGS_POWER_UP = regs_reset(1'b1);

   sws_seq_type r;
   sws_seq_type next_r;

   // Next-state logic of the whole sequencer
   always_comb begin
      logic [`SWS_IDX_W-1:0] idx;
      logic                  present;
      logic                  sys_rst;
      logic                  pending;
      logic                  key_nmi;
      logic [7:0]            rd;
      idx     = addr_index(paddr);
      present = reg_present(idx);
      sys_rst = 1'b0;
      pending = 1'b0;
      key_nmi = 1'b0;
      rd      = 8'h00;
      next_r  = r;

      // Pin synchronizers
      next_r.rst_s1 = reset_pin_n;
      next_r.rst_s2 = r.rst_s1;
      next_r.poc_s1 = poc_detect;
      next_r.poc_s2 = r.poc_s1;
      next_r.key_s1 = key_return_n;
      next_r.key_s2 = r.key_s1;

      // Reset sources and wake causes
      sys_rst = !r.rst_s2 || wdt_overflow || r.poc_s2;
      pending = |(r.regs[`SWS_IDX_IRQ_REQ] & ~r.regs[`SWS_IDX_IRQ_MASK]);
      key_nmi = !r.key_s2;

      // One-cycle outputs
      next_r.pready      = 1'b0;
      next_r.vector_req  = 1'b0;
      next_r.resume_next = 1'b0;

      // APB setup phase: latch answer for the access phase
      if (psel && !penable && !r.pready) begin
         next_r.pready  = 1'b1;
         next_r.pslverr = !present;
         if (idx == `SWS_IDX_STATUS) begin
            rd = {(r.cnt != '0), r.core_run, r.nmi_wake, r.pins_hiz,
                  r.ram_retain, r.from_stop, r.stop_active, r.pc_valid};
         end else if (present) begin
            rd = r.regs[idx];
         end
         next_r.prdata = {24'h000000, rd};
      end

      // APB access phase: write takes effect here
      if (psel && penable && r.pready && pwrite && !r.pslverr && pstrb[0] &&
          idx != `SWS_IDX_STATUS && idx != `SWS_IDX_POC_FLAGS) begin
         next_r.regs[idx] = pwdata[7:0];
      end

      // Request flags: hardware set wins over software write
      next_r.regs[`SWS_IDX_IRQ_REQ] = next_r.regs[`SWS_IDX_IRQ_REQ] | irq_lines;

      // Sequencer
      unique case (r.state)
         // Run until stop
         ST_RUN: begin
            if (stop_request) begin
               next_r.state       = ST_STOP;
               next_r.stop_active = 1'b1;
               next_r.core_run    = 1'b0;
               next_r.osc_enable  = 1'b0;
            end
         end

         // Wait for a wake source
         ST_STOP: begin
            if (key_nmi || pending) begin
               next_r.state      = ST_WAKE_WAIT;
               next_r.nmi_wake   = key_nmi;
               next_r.osc_enable = 1'b1;
               next_r.cnt        = wake_load(r.regs[`SWS_IDX_STAB_SEL][2:0]);
            end
         end

         // Wake settling wait
         ST_WAKE_WAIT: begin
            if (r.cnt == '0) begin
               next_r.state       = ST_RUN;
               next_r.stop_active = 1'b0;
               next_r.core_run    = 1'b1;
               if (r.nmi_wake) begin
                  next_r.vector_req  = 1'b1;
                  next_r.vector_kind = VEC_KEY_NMI;
               end else if (r.regs[`SWS_IDX_PSW][`SWS_PSW_IE_BIT]) begin
                  next_r.vector_req  = 1'b1;
                  next_r.vector_kind = VEC_MASKABLE;
               end else begin
                  next_r.resume_next = 1'b1;
               end
               next_r.nmi_wake = 1'b0;
            end else begin
               next_r.cnt = r.cnt - `SWS_CNT_W'(1);
            end
         end

         // Held in reset
         ST_SYS_RESET: begin
            if (!r.from_stop) begin
               next_r.regs = regs_reset(r.poc_cause);
            end
            next_r.poc_cause = r.poc_cause | r.poc_s2;
            if (!sys_rst) begin
               next_r.state      = ST_RESET_WAIT;
               next_r.osc_enable = 1'b1;
               next_r.cnt        = reset_load();
               if (!r.from_stop) begin
                  next_r.regs = regs_reset(r.poc_cause);
               end
            end
         end

         // Reset settling wait
         ST_RESET_WAIT: begin
            if (r.cnt == '0) begin
               if (r.from_stop) begin
                  next_r.regs = regs_reset(r.poc_cause);
               end
               next_r.state       = ST_RUN;
               next_r.pins_hiz    = 1'b0;
               next_r.pc_valid    = 1'b1;
               next_r.core_run    = 1'b1;
               next_r.stop_active = 1'b0;
               next_r.from_stop   = 1'b0;
               next_r.poc_cause   = 1'b0;
               next_r.vector_req  = 1'b1;
               next_r.vector_kind = VEC_RESET;
               next_r.vector_addr = `SWS_RESET_VECTOR_ADDR;
            end else begin
               next_r.cnt = r.cnt - `SWS_CNT_W'(1);
            end
         end

         // Undefined code: restart the reset sequence
         default: begin
            next_r.state = ST_SYS_RESET;
         end
      endcase

      // Any reset source forces the reset state from anywhere
      if (sys_rst && r.state != ST_SYS_RESET) begin
         next_r.state      = ST_SYS_RESET;
         next_r.from_stop  = r.from_stop || r.state == ST_STOP ||
                             r.state == ST_WAKE_WAIT;
         next_r.ram_retain = next_r.from_stop;
         next_r.poc_cause  = r.poc_s2;
         next_r.pins_hiz   = 1'b1;
         next_r.core_run   = 1'b0;
         next_r.pc_valid   = 1'b0;
         next_r.nmi_wake   = 1'b0;
         next_r.osc_enable = !next_r.from_stop;
         next_r.cnt        = '0;
         next_r.vector_req = 1'b0;
         next_r.resume_next = 1'b0;
      end

      // Port pins: floating in reset, else per direction
      next_r.port0_out  = next_r.regs[`SWS_IDX_PORT0_LATCH];
      next_r.port2_out  = next_r.regs[`SWS_IDX_PORT2_LATCH];
      next_r.port0_oe_n = next_r.regs[`SWS_IDX_PORT0_DIR] | {8{next_r.pins_hiz}};
      next_r.port2_oe_n = next_r.regs[`SWS_IDX_PORT2_DIR] | {8{next_r.pins_hiz}};
   end

   // State register; power-up acts as a supply-detect reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r             <= '0;
         r.state       <= ST_SYS_RESET;
         r.regs        <= REGS_POWER_UP;
         r.poc_cause   <= 1'b1;
         r.rst_s1      <= 1'b1;
         r.rst_s2      <= 1'b1;
         r.key_s1      <= 1'b1;
         r.key_s2      <= 1'b1;
         r.pins_hiz    <= 1'b1;
         r.osc_enable  <= 1'b1;
         r.vector_kind <= VEC_NONE;
         r.port0_oe_n  <= 8'hFF;
         r.port2_oe_n  <= 8'hFF;
      end else begin
         r <= next_r;
      end
   end

   // Outputs straight from the state register
   assign prdata      = r.prdata;
   assign pready      = r.pready;
   assign pslverr     = r.pslverr;
   assign pins_hiz    = r.pins_hiz;
   assign core_run    = r.core_run;
   assign pc_valid    = r.pc_valid;
   assign vector_req  = r.vector_req;
   assign vector_kind = r.vector_kind;
   assign vector_addr = r.vector_addr;
   assign resume_next = r.resume_next;
   assign stop_active = r.stop_active;
   assign osc_enable  = r.osc_enable;
   assign ram_retain  = r.ram_retain;
   assign port0_out   = r.port0_out;
   assign port0_oe_n  = r.port0_oe_n;
   assign port2_out   = r.port2_out;
   assign port2_oe_n  = r.port2_oe_n;

endmodule

// file: tb/sws_sequencer_checker.sv
// Port assertions for the stop/wake and reset sequencer
`timescale 1ns/100ps
module sws_checker #(
   parameter int STAB_MID_CYC   = 16,
   parameter int STAB_LONG_CYC  = 32,
   parameter int STAB_RESET_CYC = 16
) (
   input wire logic                 pclk,
   input wire logic                 presetn,
   input wire logic [7:0]           paddr,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [31:0]          pwdata,
   input wire logic [3:0]           pstrb,
   input wire logic                 pready,
   input wire logic                 pslverr,
   input wire logic                 reset_pin_n,
   input wire logic                 poc_detect,
   input wire logic                 wdt_overflow,
   input wire logic                 pins_hiz,
   input wire logic                 core_run,
   input wire logic                 pc_valid,
   input wire logic                 vector_req,
   input wire sws_pkg::sws_vec_type vector_kind,
   input wire logic [15:0]          vector_addr,
   input wire logic                 resume_next,
   input wire logic                 stop_active,
   input wire logic                 osc_enable,
   input wire logic [7:0]           port0_oe_n,
   input wire logic [7:0]           port2_oe_n
);
   import sws_pkg::*;
   localparam int RST_LO = STAB_RESET_CYC;
   localparam int RST_HI = STAB_RESET_CYC + 6;
   logic [2:0]  code;
   logic [17:0] wcnt;
   logic [17:0] wexp;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Select code as last written, reset value on any reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn || pins_hiz) begin
         code <= 3'b100;
      end else if (psel && penable && pready && pwrite && pstrb[0] && paddr[6:2] == 5'h00) begin
         code <= pwdata[2:0];
      end
   end
   // Cycles spent with the oscillator running inside stop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn || !(stop_active && osc_enable)) begin
         wcnt <= 18'h0;
      end else begin
         wcnt <= wcnt + 18'h1;
      end
   end
   // Expected wake wait for the tracked code
   always_comb begin
      case (code)
         3'b000:  wexp = 18'd4096;
         3'b010:  wexp = 18'(STAB_MID_CYC);
         default: wexp = 18'(STAB_LONG_CYC);
      endcase
   end
   hiz_core_off_a: assert property (
      pins_hiz |-> !pc_valid && !core_run) else $error("core live while pins float");
   hiz_oe_off_a: assert property (
      pins_hiz |-> port0_oe_n == 8'hFF && port2_oe_n == 8'hFF) else $error("pin driven in reset");
   reset_vec_a: assert property (
      vector_req && vector_kind == VEC_RESET |-> vector_addr == 16'h0000 && pc_valid && !pins_hiz)
      else $error("bad reset entry");
   stop_entry_a: assert property (
      $rose(stop_active) |-> !osc_enable && !core_run) else $error("stop with clock running");
   wake_exit_a: assert property (
      $fell(stop_active) |-> vector_req || resume_next) else $error("stop left without entry");
   wake_count_a: assert property (
      $fell(stop_active) && (resume_next || (vector_req && vector_kind != VEC_RESET))
      |-> wcnt == wexp) else $error("wake wait length wrong");
   rst_wait_a: assert property (
      ($rose(reset_pin_n) || $fell(poc_detect)) && pins_hiz
      |-> ##[RST_LO:RST_HI] (vector_req && vector_kind == VEC_RESET)) else $error("reset wait wrong");
   src_reset_a: assert property (
      $fell(reset_pin_n) || wdt_overflow |-> ##[1:4] pins_hiz) else $error("reset source missed");
   stop_hold_a: assert property (
      $fell(reset_pin_n) && stop_active |-> ##[1:4] (pins_hiz && stop_active))
      else $error("stop lost in reset");
   apb_ready_a: assert property (
      psel && !penable |=> pready) else $error("no access answer");
   cover property (resume_next);
   cover property (vector_req && vector_kind == VEC_KEY_NMI);
   cover property (pins_hiz && stop_active);
   cover property (pready && pslverr);
endmodule

bind sws_sequencer sws_checker #(.STAB_MID_CYC(STAB_MID_CYC), .STAB_LONG_CYC(STAB_LONG_CYC),
   .STAB_RESET_CYC(STAB_RESET_CYC)) u_check (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
   .reset_pin_n(reset_pin_n), .poc_detect(poc_detect), .wdt_overflow(wdt_overflow),
   .pins_hiz(pins_hiz), .core_run(core_run), .pc_valid(pc_valid), .vector_req(vector_req),
   .vector_kind(vector_kind), .vector_addr(vector_addr), .resume_next(resume_next),
   .stop_active(stop_active), .osc_enable(osc_enable), .port0_oe_n(port0_oe_n),
   .port2_oe_n(port2_oe_n));

// file: tb/sws_core_model.sv
// Behavioural core, interrupt sources and reset pin facing the sequencer
`timescale 1ns/100ps
module sws_core_model (
   input  wire logic pclk,
   output logic       reset_pin_n,
   output logic       poc_detect,
   output logic       key_return_n,
   output logic       wdt_overflow,
   output logic       stop_request,
   output logic [7:0] irq_lines
);
   localparam int LOW_CYC = 250;
   // Idle levels from time zero
   initial begin
      reset_pin_n = 1'b1;
      poc_detect = 1'b0;
      key_return_n = 1'b1;
      wdt_overflow = 1'b0;
      stop_request = 1'b0;
      irq_lines = 8'h00;
   end
   // Generic one-signal pulses
   task automatic exec_stop();
      @(posedge pclk) stop_request <= 1'b1;
      @(posedge pclk) stop_request <= 1'b0;
   endtask
   task automatic irq_pulse(input logic [7:0] bits);
      @(posedge pclk) irq_lines <= bits;
      @(posedge pclk) irq_lines <= 8'h00;
   endtask
   task automatic wdt_pulse();
      @(posedge pclk) wdt_overflow <= 1'b1;
      @(posedge pclk) wdt_overflow <= 1'b0;
   endtask
   task automatic poc_pulse();
      @(posedge pclk) poc_detect <= 1'b1;
      repeat (8) @(posedge pclk);
      poc_detect <= 1'b0;
   endtask
   task automatic key_press();
      @(posedge pclk) key_return_n <= 1'b0;
      repeat (4) @(posedge pclk);
      key_return_n <= 1'b1;
   endtask
   // Pin held low for 10 us at 40 ns per cycle
   task automatic pin_reset();
      @(posedge pclk) reset_pin_n <= 1'b0;
      repeat (LOW_CYC) @(posedge pclk);
      reset_pin_n <= 1'b1;
   endtask
endmodule

// file: tb/test_stop_wake_and_reset_sequencer.sv
// Directed bench for the stop/wake and reset sequencer
`timescale 1ns/100ps
module test_stop_wake_and_reset_sequencer;
   import sws_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, irq_lines, port0_out, port0_oe_n, port2_out, port2_oe_n;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb, strb = 4'hF;
   logic        reset_pin_n, poc_detect, key_return_n, wdt_overflow, stop_request;
   logic        pins_hiz, core_run, pc_valid, vector_req, resume_next, stop_active;
   logic        osc_enable, ram_retain;
   logic [15:0] vector_addr;
   sws_vec_type vector_kind;
   int          errors = 0;
   int          total_checks = 0;
   logic [7:0]  rst_tab [0:18] = '{8'h04, 8'h02, 8'h02, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00,
      8'hFF, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [2:0]  code_tab [0:3] = '{3'b000, 3'b010, 3'b100, 3'b110};
   always #20 pclk = ~pclk;
   sws_sequencer #(.EEPROM_VARIANT(1), .STAB_MID_CYC(16), .STAB_LONG_CYC(32),
      .STAB_RESET_CYC(16)) dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .reset_pin_n(reset_pin_n), .poc_detect(poc_detect),
      .key_return_n(key_return_n), .wdt_overflow(wdt_overflow), .stop_request(stop_request),
      .irq_lines(irq_lines), .pins_hiz(pins_hiz), .core_run(core_run), .pc_valid(pc_valid),
      .vector_req(vector_req), .vector_kind(vector_kind), .vector_addr(vector_addr),
      .resume_next(resume_next), .stop_active(stop_active), .osc_enable(osc_enable),
      .ram_retain(ram_retain), .port0_out(port0_out), .port0_oe_n(port0_oe_n),
      .port2_out(port2_out), .port2_oe_n(port2_oe_n));
   sws_core_model core (.pclk(pclk), .reset_pin_n(reset_pin_n), .poc_detect(poc_detect),
      .key_return_n(key_return_n), .wdt_overflow(wdt_overflow), .stop_request(stop_request),
      .irq_lines(irq_lines));
   // Verdict and end of run
   task automatic final_report();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   // One APB transfer, held until pready is seen at an edge
   task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d,
      output logic [31:0] q, output logic e);
      int n;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata, pstrb} <= {1'b1, 1'b0, w, a, {4{d}}, strb};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         errors++;
         final_report();
      end
      q = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      logic        e;
      apb(a, 1'b1, d, q, e);
   endtask
   task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] x,
      input logic xe);
      logic [31:0] q;
      logic        e;
      apb(a, 1'b0, 8'h00, q, e);
      chk(name, {23'h0, xe, x}, {23'h0, e, q[7:0]});
      chk({name, " upper"}, 32'h0, {q[31:8], 8'h00});
   endtask
   task automatic chk_regs();
      for (int i = 0; i < 19; i++) begin
         rd_chk($sformatf("reg %0d", i), 8'(i * 4), rst_tab[i], 1'b0);
      end
   endtask
   // Waits for a vectored entry of kind k, or a plain resume when k is none
   task automatic wait_entry(input string name, input sws_vec_type k);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         #1;
         n++;
      end while (vector_req !== 1'b1 && resume_next !== 1'b1 && n < 6000);
      if (n >= 6000) begin
         errors++;
         final_report();
      end
      if (k == VEC_NONE) chk(name, 32'h1, {30'h0, vector_req, resume_next});
      else chk(name, {28'h0, 2'b10, k}, {28'h0, vector_req, resume_next, vector_kind});
   endtask
   // Main sequence
   initial begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      wait_entry("power-on entry", VEC_RESET);
      chk("vector address", 32'h0, {16'h0, vector_addr});
      chk_regs();
      rd_chk("status", 8'h50, 8'h41, 1'b0);
      strb = 4'hE;
      wr(8'h48, 8'h33);
      strb = 4'hF;
      rd_chk("strobe off", 8'h48, 8'h00, 1'b0);
      rd_chk("poc flags", 8'h4C, 8'h04, 1'b0);
      rd_chk("unmapped", 8'h54, 8'h00, 1'b1);
      wr(8'h14, 8'h0F);
      wr(8'h0C, 8'hA5);
      @(posedge pclk);
      #1;
      chk("port0", 32'hA50F, {16'h0, port0_out, port0_oe_n});
      wr(8'h20, 8'hFE);
      for (int i = 0; i < 4; i++) begin
         wr(8'h00, {5'h0, code_tab[i]});
         wr(8'h04, i[0] ? 8'h02 : 8'h82);
         wr(8'h1C, 8'h00);
         core.exec_stop();
         core.irq_pulse(8'h02);
         repeat (40) @(posedge pclk);
         #1;
         chk("masked keeps stop", 32'h1, {31'h0, stop_active});
         core.irq_pulse(8'h01);
         wait_entry("irq wake", i[0] ? VEC_NONE : VEC_MASKABLE);
      end
      wr(8'h04, 8'h02);
      wr(8'h1C, 8'h00);
      core.exec_stop();
      core.key_press();
      wait_entry("key wake", VEC_KEY_NMI);
      core.exec_stop();
      fork
         core.pin_reset();
         begin
            repeat (20) @(posedge pclk);
            #1;
            chk("reset in stop", 32'h3, {30'h0, stop_active, pins_hiz});
         end
      join
      wait_entry("reset from stop", VEC_RESET);
      chk("ram kept", 32'h1, {31'h0, ram_retain});
      chk("ports", 32'h00FF00FF, {port0_out, port0_oe_n, port2_out, port2_oe_n});
      chk_regs();
      rd_chk("poc flags pin", 8'h4C, 8'h00, 1'b0);
      core.wdt_pulse();
      wait_entry("watchdog reset", VEC_RESET);
      chk("ram lost", 32'h0, {31'h0, ram_retain});
      core.poc_pulse();
      wait_entry("supply reset", VEC_RESET);
      rd_chk("poc flags supply", 8'h4C, 8'h04, 1'b0);
      final_report();
   end
endmodule
